/* spsc_params.svh */
// constants for the set-point and phase scroll controller
`ifndef SPSC_PARAMS_SVH
`define SPSC_PARAMS_SVH
`define SPSC_SLOW_MS 250
`define SPSC_FAST_MS 20
`define SPSC_SLOW_SPAN_MS 2000
`define SPSC_CLK_HZ 20000000
`define SPSC_CYC_PER_MS (`SPSC_CLK_HZ / 1000)
`define SPSC_SLOW_CYC (`SPSC_SLOW_MS * `SPSC_CYC_PER_MS)
`define SPSC_FAST_CYC (`SPSC_FAST_MS * `SPSC_CYC_PER_MS)
`define SPSC_SLOW_STEPS (`SPSC_SLOW_SPAN_MS / `SPSC_SLOW_MS)
`define SPSC_FOL_RATIO 1'b0
`define SPSC_FOL_INDEX 1'b1
`define SPSC_OL_CODE_0 2'h0
`define SPSC_OL_CODE_2 2'h2
// register offsets (word addresses)
`define SPSC_REG_CTRL 4'h0
`define SPSC_REG_MSTEP 4'h1
`define SPSC_REG_RSTEP 4'h2
`define SPSC_REG_PSTEP 4'h3
`define SPSC_REG_JSTEP 4'h4
`define SPSC_REG_MSP 4'h5
`define SPSC_REG_RSP 4'h6
`define SPSC_REG_PSP 4'h7
`define SPSC_REG_JSP 4'h8
`define SPSC_REG_OFFS 4'h9
`define SPSC_REG_STAT 4'ha
`define SPSC_REG_DISP 4'hb
`define SPSC_MAX_DEF 32'h0000_ffff
`endif

/* spsc_pkg.sv */
// types for the set-point and phase scroll controller
package spsc_pkg;
    typedef enum logic [1:0] {
        SPSC_MASTER = 2'h0,
        SPSC_FOLLOW = 2'h1,
        SPSC_JOG = 2'h3
    } spsc_mode_e;
    typedef enum logic [1:0] {
        SPSC_IDLE = 2'h0,
        SPSC_SLOW = 2'h1,
        SPSC_FAST = 2'h3
    } spsc_state_e;
endpackage

/* spsc_sync_if.sv */
// carrier for the synchronised pin levels
`timescale 1ns/1ps
interface spsc_sync_if;
    logic [7:0] lvl;
    modport src (output lvl);
    modport dst (input lvl);
endinterface

/* spsc_sync.sv */
// two-flop synchroniser for the keypad and switch pins
`timescale 1ns/1ps
module spsc_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // raw pins in, synchronised levels out
    input wire logic [7:0] pin_i,
    spsc_sync_if.src out
);
    logic [7:0] meta_q;
    logic [7:0] lvl_q;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 8'h00;
            lvl_q <= 8'h00;
        end else begin
            meta_q <= pin_i;
            lvl_q <= meta_q;
        end
    end
    assign out.lvl = lvl_q;
endmodule

/* spsc_scroll.sv */
// set-point and phase scroll controller with avalon-mm registers
// Notes on behaviour
// R01 - first two seconds: step every 250 ms
// R02 - after two seconds: step every 20 ms
// R03 - step while requested, stop at limit
// R04 - display scrolled value, restore item afterwards
// R05 - steps take effect immediately on outputs
// R06 - set-point scroll alters active set-point only
// R07 - step size from per-mode step setting
// R08 - up/down keys unlocked, or switch closed
// R09 - right advances, left retards, or switches
// R10 - show offset, step by phase step
// R11 - speed trim follows offset change
// R12 - release stops trim, net displacement kept
// R13 - no advance/retard in jog mode
// R14 - encoder loop closed: open-loop code 0/2
// R15 - index follower needs switch closed, code 2
// R16 - index loop corrects to phase set-point
// R17 - advance/retard never touch phase set-points
// R18 - offset only by scroll, cleared on mode change
// R19 - master/ratio position: start, offset, speed, time
// R20 - switch scroll active exactly while closed
// R21 - clamp at limit, no wrap
//
// The register offsets and the Avalon-MM slave port were decided locally.
`include "spsc_params.svh"
`timescale 1ns/1ps
module spsc_scroll #(
    parameter int unsigned SLOW_CYC = `SPSC_SLOW_CYC,
    parameter int unsigned FAST_CYC = `SPSC_FAST_CYC,
    parameter logic [31:0] SP_MAX = `SPSC_MAX_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // keypad keys and switch contacts (raw pins)
    input wire logic key_up_i,
    input wire logic key_down_i,
    input wire logic key_right_i,
    input wire logic key_left_i,
    input wire logic sw_up_i,
    input wire logic sw_down_i,
    input wire logic sw_adv_i,
    input wire logic sw_ret_i,
    // operating context
    input wire logic [1:0] op_mode_i,
    input wire logic sw_open_loop_i,
    input wire logic run_ok_i,
    // outputs
    output logic [31:0] disp_value_o,
    output logic disp_scroll_o,
    output logic [31:0] active_sp_o,
    output logic signed [31:0] phase_offset_o,
    output logic signed [31:0] speed_trim_o,
    output logic adv_ret_en_o
);
    spsc_sync_if sync_bus ();
    logic [7:0] lvl;
    logic sp_up, sp_dn, adv, ret;

    // keys and switches are asynchronous contacts
    spsc_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i({sw_ret_i, sw_adv_i, sw_down_i, sw_up_i,
                key_left_i, key_right_i, key_down_i, key_up_i}),
        .out(sync_bus)
    );
    assign lvl = sync_bus.lvl;

    // control register fields, step and set-point registers, offset and step timer state
    logic lock_q, level0_q, fol_cfg_q, ol_assigned_q;
    logic [1:0] ol_code_q;
    logic [5:0] disp_item_q;
    logic [31:0] mstep_q, rstep_q, pstep_q, jstep_q;
    logic [31:0] msp_q, rsp_q, psp_q, jsp_q;
    logic signed [31:0] offs_q;
    logic signed [31:0] offs_start_q;
    spsc_pkg::spsc_state_e st_q;
    logic [31:0] tick_q;
    logic [3:0] nslow_q;
    logic [1:0] mode_q;
    logic step;

    // keys count only unlocked at keypad level zero
    wire key_ok = !lock_q && level0_q; // R08 R09
    // switch requests last exactly while closed
    assign sp_up = (lvl[0] && key_ok) || lvl[4]; // R08 R20
    assign sp_dn = (lvl[1] && key_ok) || lvl[5]; // R08 R20
    wire adv_raw = (lvl[2] && key_ok) || lvl[6]; // R09 R20
    wire ret_raw = (lvl[3] && key_ok) || lvl[7]; // R09 R20

    // loop conditions for advance/retard
    wire ol_keep_enc = !sw_open_loop_i || !ol_assigned_q ||
        ol_code_q == `SPSC_OL_CODE_0 || ol_code_q == `SPSC_OL_CODE_2; // R14
    wire idx_open = ol_assigned_q && sw_open_loop_i &&
        ol_code_q == `SPSC_OL_CODE_2; // R15
    always_comb begin
        unique case (spsc_pkg::spsc_mode_e'(op_mode_i))
            spsc_pkg::SPSC_MASTER: adv_ret_en_o = ol_keep_enc; // R14
            spsc_pkg::SPSC_FOLLOW:
                adv_ret_en_o = (fol_cfg_q == `SPSC_FOL_INDEX) ?
                    idx_open : ol_keep_enc; // R15
            default: adv_ret_en_o = 1'b0; // R13
        endcase
    end
    assign adv = adv_raw && !ret_raw && adv_ret_en_o;
    assign ret = ret_raw && !adv_raw && adv_ret_en_o;
    wire sp_req = sp_up ^ sp_dn;
    wire any_req = sp_req || adv || ret;

    // step timer: eight slow periods then fast periods
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= spsc_pkg::SPSC_IDLE;
            tick_q <= 32'h0000_0000;
            nslow_q <= 4'h0;
        end else if (!any_req) begin
            st_q <= spsc_pkg::SPSC_IDLE; // R03
            tick_q <= 32'h0000_0000;
            nslow_q <= 4'h0;
        end else begin
            unique case (st_q)
                spsc_pkg::SPSC_IDLE: begin
                    st_q <= spsc_pkg::SPSC_SLOW;
                    tick_q <= 32'h0000_0000;
                end
                spsc_pkg::SPSC_SLOW: begin
                    if (tick_q == SLOW_CYC - 1) begin // R01
                        tick_q <= 32'h0000_0000;
                        nslow_q <= nslow_q + 4'h1;
                        if (nslow_q == 4'(`SPSC_SLOW_STEPS - 1))
                            st_q <= spsc_pkg::SPSC_FAST; // R02
                    end else begin
                        tick_q <= tick_q + 32'h0000_0001;
                    end
                end
                spsc_pkg::SPSC_FAST: begin
                    if (tick_q == FAST_CYC - 1) // R02
                        tick_q <= 32'h0000_0000;
                    else
                        tick_q <= tick_q + 32'h0000_0001;
                end
                default: st_q <= spsc_pkg::SPSC_IDLE;
            endcase
        end
    end
    // first step at scroll entry, then at each period end
    assign step = any_req && ((st_q == spsc_pkg::SPSC_IDLE) ||
        (st_q == spsc_pkg::SPSC_SLOW && tick_q == SLOW_CYC - 1) ||
        (st_q == spsc_pkg::SPSC_FAST && tick_q == FAST_CYC - 1));

    // saturating add/subtract, never wraps
    function automatic logic [31:0] sat_step(input logic [31:0] v,
            input logic [31:0] s, input logic up);
        logic [32:0] t;
        t = 33'h0_0000_0000;
        if (up) begin
            t = {1'b0, v} + {1'b0, s};
            sat_step = (t > {1'b0, SP_MAX}) ? SP_MAX : t[31:0]; // R21
        end else begin
            sat_step = (v < s) ? 32'h0000_0000 : v - s; // R21
        end
    endfunction

    wire bus_wr = avs_write && !avs_read;
    // configuration and set-point registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_q <= 1'b0;
            level0_q <= 1'b1;
            fol_cfg_q <= 1'b0;
            ol_assigned_q <= 1'b0;
            ol_code_q <= 2'h0;
            disp_item_q <= 6'h00;
            mstep_q <= 32'h0000_0001;
            rstep_q <= 32'h0000_0001;
            pstep_q <= 32'h0000_0001;
            jstep_q <= 32'h0000_0001;
            msp_q <= 32'h0000_0000;
            rsp_q <= 32'h0000_0000;
            psp_q <= 32'h0000_0000;
            jsp_q <= 32'h0000_0000;
        end else begin
            if (bus_wr) begin
                unique case (avs_address)
                    `SPSC_REG_CTRL: begin
                        lock_q <= avs_writedata[0];
                        level0_q <= avs_writedata[1];
                        fol_cfg_q <= avs_writedata[2];
                        ol_assigned_q <= avs_writedata[3];
                        ol_code_q <= avs_writedata[5:4];
                        disp_item_q <= avs_writedata[13:8];
                    end
                    `SPSC_REG_MSTEP: mstep_q <= avs_writedata; // R07
                    `SPSC_REG_RSTEP: rstep_q <= avs_writedata; // R07
                    `SPSC_REG_PSTEP: pstep_q <= avs_writedata; // R07
                    `SPSC_REG_JSTEP: jstep_q <= avs_writedata; // R07
                    `SPSC_REG_MSP: msp_q <= avs_writedata;
                    `SPSC_REG_RSP: rsp_q <= avs_writedata;
                    `SPSC_REG_PSP: psp_q <= avs_writedata;
                    `SPSC_REG_JSP: jsp_q <= avs_writedata;
                    default: ;
                endcase
            end
            // scroll wins over a bus write in the same cycle
            if (step && sp_req) begin // R06
                unique case (spsc_pkg::spsc_mode_e'(op_mode_i))
                    spsc_pkg::SPSC_MASTER:
                        msp_q <= sat_step(msp_q, mstep_q, sp_up); // R07
                    spsc_pkg::SPSC_FOLLOW:
                        if (fol_cfg_q == `SPSC_FOL_INDEX)
                            psp_q <= sat_step(psp_q, pstep_q, sp_up); // R16
                        else
                            rsp_q <= sat_step(rsp_q, rstep_q, sp_up);
                    default: jsp_q <= sat_step(jsp_q, jstep_q, sp_up);
                endcase
            end
        end
    end

    // phase offset: only advance/retard steps it; a mode change clears it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            offs_q <= 32'sh0000_0000; // R18
            mode_q <= 2'h0;
        end else begin
            mode_q <= op_mode_i;
            if (mode_q != op_mode_i)
                offs_q <= 32'sh0000_0000; // R18
            else if (step && (adv || ret))
                offs_q <= adv ? offs_q + $signed(pstep_q) :
                    offs_q - $signed(pstep_q); // R10 R17
        end
    end

    // remember offset at start of each advance/retard burst
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            offs_start_q <= 32'sh0000_0000;
        else if (!(adv || ret))
            offs_start_q <= offs_q; // R12
    end

    // speed trim: offset change since the start of the current burst
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            speed_trim_o <= 32'sh0000_0000;
        else
            speed_trim_o <= offs_q - offs_start_q; // R11 R12 R19
    end

    // display and drive outputs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_value_o <= 32'h0000_0000;
            disp_scroll_o <= 1'b0;
            active_sp_o <= 32'h0000_0000;
        end else begin
            disp_scroll_o <= any_req; // R04
            if (adv || ret)
                disp_value_o <= offs_q; // R10
            else if (sp_req)
                disp_value_o <= active_sp_o; // R04 R21
            else
                disp_value_o <= {26'h000_0000, disp_item_q}; // R04
            unique case (spsc_pkg::spsc_mode_e'(op_mode_i))
                spsc_pkg::SPSC_MASTER: active_sp_o <= msp_q; // R05
                spsc_pkg::SPSC_FOLLOW:
                    active_sp_o <= fol_cfg_q ? psp_q : rsp_q; // R05
                default: active_sp_o <= jsp_q; // R05
            endcase
        end
    end
    assign phase_offset_o = offs_q;

    // bus answers in the cycle a request appears
    assign avs_waitrequest = 1'b0;
    always_comb begin
        unique case (avs_address)
            `SPSC_REG_CTRL: avs_readdata = {18'h0_0000, disp_item_q,
                2'h0, ol_code_q, ol_assigned_q, fol_cfg_q, level0_q,
                lock_q};
            `SPSC_REG_MSTEP: avs_readdata = mstep_q;
            `SPSC_REG_RSTEP: avs_readdata = rstep_q;
            `SPSC_REG_PSTEP: avs_readdata = pstep_q;
            `SPSC_REG_JSTEP: avs_readdata = jstep_q;
            `SPSC_REG_MSP: avs_readdata = msp_q;
            `SPSC_REG_RSP: avs_readdata = rsp_q;
            `SPSC_REG_PSP: avs_readdata = psp_q;
            `SPSC_REG_JSP: avs_readdata = jsp_q;
            `SPSC_REG_OFFS: avs_readdata = offs_q;
            `SPSC_REG_STAT: avs_readdata = {26'h000_0000, run_ok_i,
                adv_ret_en_o, st_q, disp_scroll_o, any_req};
            `SPSC_REG_DISP: avs_readdata = disp_value_o;
            default: avs_readdata = 32'h0000_0000;
        endcase
    end
endmodule

/* spsc_scroll_checker.sv */
// port assertions for the scroll controller
`timescale 1ns/1ps
module spsc_scroll_checker #(
    parameter int unsigned FAST_CYC = 4,
    parameter logic [31:0] SP_MAX = 32'h0000_ffff
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // watched ports
    input wire logic sw_adv_i,
    input wire logic [1:0] op_mode_i,
    input wire logic [31:0] disp_value_o,
    input wire logic disp_scroll_o,
    input wire logic [31:0] active_sp_o,
    input wire logic signed [31:0] phase_offset_o,
    input wire logic adv_ret_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [7:0] gap_q;
    // cycles since last offset step; parked high while idle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) gap_q <= 8'hff;
        else if (!disp_scroll_o) gap_q <= 8'hff;
        else if ($changed(phase_offset_o)) gap_q <= 8'h00;
        else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end
    sequence s_adv_held;
        $rose(sw_adv_i) && adv_ret_en_o ##1 (sw_adv_i && adv_ret_en_o)[*4];
    endsequence
    a_jog_refused: assert property (
        op_mode_i == 2'h3 |-> !adv_ret_en_o) else $error("jog permit");
    a_jog_still: assert property (
        op_mode_i == 2'h3 && $past(op_mode_i, 4) == 2'h3
        |-> $stable(phase_offset_o)) else $error("jog offset moved");
    a_mode_clears: assert property (
        $changed(op_mode_i) |-> ##[0:3] phase_offset_o == 32'sh0)
        else $error("offset kept over mode change");
    a_sp_clamped: assert property (
        active_sp_o <= SP_MAX) else $error("set-point beyond limit");
    a_fast_spacing: assert property (
        $changed(phase_offset_o) && disp_scroll_o && $stable(op_mode_i)
        |-> gap_q >= FAST_CYC - 1) else $error("steps too close");
    a_adv_enters: assert property (
        s_adv_held |-> disp_scroll_o) else $error("advance not entered");
    a_disp_tracks: assert property (
        sw_adv_i && $past(sw_adv_i, 4) && disp_scroll_o
        |-> ##[0:1] disp_value_o == phase_offset_o)
        else $error("display not offset");
    a_idle_still: assert property (
        !disp_scroll_o && !$past(disp_scroll_o)
        && op_mode_i == $past(op_mode_i, 4) |-> $stable(phase_offset_o))
        else $error("offset moved while idle");
endmodule

/* spsc_pad_model.sv */
// keypad keys and remote switch contacts
`timescale 1ns/1ps
module spsc_pad_model (
    // clock and held contacts
    input wire logic clk_i,
    input wire logic [7:0] hold_i,
    // contact levels, high when pressed or closed
    output logic [7:0] pin_o = 8'h00
);
    // bounce-free contacts; level follows the hold one edge late
    always_ff @(posedge clk_i) begin
        pin_o <= hold_i;
    end
endmodule

/* test_spsc_scroll.sv */
// self-checking bench for the scroll controller
`timescale 1ns/1ps
module test_spsc_scroll;
    localparam int SLOW = 20;
    localparam int FAST = 4;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, disp_value_o, active_sp_o, q;
    logic avs_waitrequest, disp_scroll_o, adv_ret_en_o;
    logic [7:0] hold = 8'h00;
    logic [7:0] pin;
    logic [1:0] op_mode_i = 2'h0;
    logic sw_ol = 1'b0;
    logic signed [31:0] phase_offset_o, speed_trim_o, sp, off, ps;
    logic [63:0] exp_q[$];
    int gap_q[$];
    int err_count = 0;
    int n_compared = 0;
    int seed = 32'h72b2;
    logic [63:0] seen = 64'h0;
    int since = 0;
    int g;

    // clock
    always #25 clk_i = ~clk_i;
    spsc_pad_model spsc_pad_model_inst (.clk_i(clk_i), .hold_i(hold),
        .pin_o(pin));
    spsc_scroll #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) spsc_scroll_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .key_up_i(pin[0]),
        .key_down_i(pin[1]), .key_right_i(pin[2]), .key_left_i(pin[3]),
        .sw_up_i(pin[4]), .sw_down_i(pin[5]), .sw_adv_i(pin[6]),
        .sw_ret_i(pin[7]), .op_mode_i(op_mode_i), .sw_open_loop_i(sw_ol),
        .run_ok_i(1'b1), .disp_value_o(disp_value_o),
        .disp_scroll_o(disp_scroll_o), .active_sp_o(active_sp_o),
        .phase_offset_o(phase_offset_o), .speed_trim_o(speed_trim_o),
        .adv_ret_en_o(adv_ret_en_o));

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic final_report;
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one avalon-mm cycle, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [3:0] a,
            input logic [31:0] d);
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0) @(posedge clk_i);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_i);
    endtask

    // hold contact b over h step slots, noting n expected steps
    task automatic scroll(input int b, input int h, input int n,
            input logic signed [31:0] dsp, input logic signed [31:0] doff);
        int t;
        t = 4;
        for (int k = 0; k < h; k++) begin
            g = (k == 0) ? 0 : (k <= 8) ? SLOW : FAST;
            t += g;
            if (k < n) begin
                sp = sp + dsp;
                off = off + doff;
                exp_q.push_back({sp, off});
                gap_q.push_back(g);
            end
        end
        hold[b] <= 1'b1;
        repeat (t) @(posedge clk_i);
        // release right after the last step, before the next can fall
        hold[b] <= 1'b0;
        @(negedge clk_i);
        cmp(disp_scroll_o, n > 0);
        cmp(speed_trim_o, (n > 0) ? (n - 1) * doff : 0);
        repeat (12) @(posedge clk_i);
        cmp(disp_scroll_o, 1'b0);
        cmp(speed_trim_o, 0);
    endtask

    // permit for one loop configuration, compared off the edge
    task automatic permit(input logic [1:0] m, input logic [31:0] c,
            input logic ol, input logic exp);
        bus(1'b0, 4'h0, c);
        op_mode_i <= m;
        sw_ol <= ol;
        @(negedge clk_i);
        cmp(adv_ret_en_o, exp);
    endtask

    // each change of set-point or offset takes the oldest note
    always @(negedge clk_i) begin
        since++;
        if ({active_sp_o, phase_offset_o} !== seen) begin
            seen = {active_sp_o, phase_offset_o};
            if (exp_q.size() == 0) cmp(seen, {64{1'bx}});
            else begin
                cmp(seen, exp_q.pop_front());
                g = gap_q.pop_front();
                if (g != 0) cmp(since, g);
            end
            since = 0;
        end
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        final_report();
    end

    // main sequence
    initial begin
        sp = 0;
        off = 0;
        ps = ($random(seed) & 32'h0000_000f) | 32'h0000_0001;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b1, 4'hc, 32'h0);
        cmp(q, 32'h0);
        bus(1'b1, 4'h1, 32'h0);
        cmp(q, 32'h1);
        bus(1'b0, 4'h1, 32'h0000_0003);
        bus(1'b0, 4'h3, ps);
        bus(1'b1, 4'h1, 32'h0);
        cmp(q, 32'h3);
        scroll(6, 12, 12, 0, ps);
        scroll(3, 2, 2, 0, -ps);
        scroll(0, 2, 2, 3, 0);
        scroll(5, 3, 2, -3, 0);
        bus(1'b1, 4'h9, 32'h0);
        cmp(q, 10 * ps);
        off = 0;
        exp_q.push_back({sp, off});
        gap_q.push_back(0);
        op_mode_i <= 2'h3;
        repeat (6) @(posedge clk_i);
        cmp(adv_ret_en_o, 1'b0);
        scroll(6, 2, 0, 0, ps);
        scroll(0, 1, 1, 1, 0);
        sp = 0;
        exp_q.push_back({sp, off});
        gap_q.push_back(0);
        op_mode_i <= 2'h0;
        repeat (10) @(posedge clk_i);
        cmp(exp_q.size(), 0);
        // open-loop switch closed with code 1 drops the encoder loop
        permit(2'h0, 32'h0000_001a, 1'b1, 1'b0);
        permit(2'h0, 32'h0000_002a, 1'b1, 1'b1);
        permit(2'h0, 32'h0000_001a, 1'b0, 1'b1);
        permit(2'h1, 32'h0000_001a, 1'b1, 1'b0);
        permit(2'h1, 32'h0000_002e, 1'b1, 1'b1);
        permit(2'h1, 32'h0000_000e, 1'b1, 1'b0);
        permit(2'h1, 32'h0000_0006, 1'b0, 1'b0);
        permit(2'h0, 32'h0000_0002, 1'b0, 1'b1);
        final_report();
    end
endmodule

bind spsc_scroll spsc_scroll_checker #(.FAST_CYC(FAST_CYC),
    .SP_MAX(SP_MAX)) spsc_scroll_checker_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .sw_adv_i(sw_adv_i), .op_mode_i(op_mode_i),
    .disp_value_o(disp_value_o), .disp_scroll_o(disp_scroll_o),
    .active_sp_o(active_sp_o), .phase_offset_o(phase_offset_o),
    .adv_ret_en_o(adv_ret_en_o));
